// [camera_pixel_format_packer_bench.sv]
// self-checking bench for the pixel format packer
`timescale 1ns/1ps
`default_nettype none
`include "cpfp_defines.vh"
module camera_pixel_format_packer_bench;
   logic clk = 0, srst = 1, frame_start = 0, mono_sensor = 1, pix_valid = 0, slow = 0;
   logic [1:0] fmt_sel = 0;
   logic [11:0] pix_r = 0, pix_g = 0, pix_b = 0;
   wire pix_ready, byte_valid, byte_ready;
   wire [7:0] byte_data;
   int num_errors = 0, n_compared = 0;
   cpfp_packer cpfp_packer_i (.clk(clk), .srst(srst), .fmt_sel(fmt_sel),
      .frame_start(frame_start), .mono_sensor(mono_sensor), .pix_valid(pix_valid),
      .pix_r(pix_r), .pix_g(pix_g), .pix_b(pix_b), .pix_ready(pix_ready),
      .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready));
   cpfp_sink cpfp_sink_i (.clk(clk), .slow(slow), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_ready(byte_ready));
   initial forever #12.5 clk = ~clk;
   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic frame(input logic [1:0] f, input logic m, input logic s);
      @(negedge clk);
      slow = s;
      fmt_sel = f;
      mono_sensor = m;
      frame_start = 1;
      cpfp_sink_i.q.delete();
      @(negedge clk);
      frame_start = 0;
   endtask
   task automatic px(input logic [11:0] r, input logic [11:0] g, input logic [11:0] b);
      int i;
      i = 0;
      @(negedge clk);
      {pix_r, pix_g, pix_b, pix_valid} = {r, g, b, 1'b1};
      // ready is settled at the falling edge; the next rising edge takes the pixel
      while (pix_ready !== 1'b1 && i < 99) begin
         @(negedge clk);
         i++;
      end
      if (pix_ready !== 1'b1) begin
         num_errors++;
         end_of_test();
      end
      @(negedge clk);
      pix_valid = 0;
   endtask
   // first byte sits in the top of the low n bytes of e; waits a little for stray extra bytes
   task automatic exp_bytes(input logic [47:0] e, input int n);
      int i;
      for (i = 0; i < 99 && cpfp_sink_i.q.size() < n; i++) @(negedge clk);
      repeat (4) @(negedge clk);
      chk(8'(cpfp_sink_i.q.size()), 8'(n));
      for (i = 0; i < n; i++) chk(cpfp_sink_i.q[i], e[8*(n-1-i)+:8]);
   endtask
   task automatic test_yuyv;
      frame(`CPFP_FMT_YUYV, 1, 0);
      px(12'hfff, 12'hab0, 12'hfff);
      px(12'h000, 12'h340, 12'h000);
      exp_bytes(48'h00ab0034, 4);
   endtask
   task automatic test_mono8;
      frame(`CPFP_FMT_MONO8, 0, 0);
      px(12'hff0, 12'hff0, 12'hff0);
      px(12'hff0, 12'h000, 12'h000);
      px(12'h000, 12'h000, 12'h000);
      exp_bytes(48'hff4d00, 3);
   endtask
   // selection moved inside the frame must not change its packing
   task automatic test_rgb8;
      frame(`CPFP_FMT_RGB8, 0, 1);
      fmt_sel = `CPFP_FMT_MONO8;
      px(12'h123, 12'h456, 12'h789);
      px(12'hfff, 12'h000, 12'ha5f);
      exp_bytes(48'h124578ff00a5, 6);
   endtask
   task automatic test_rgb12;
      frame(`CPFP_FMT_RGB12, 0, 1);
      px(12'hfed, 12'h0a5, 12'h801);
      exp_bytes(48'hed0fa5000108, 6);
   endtask
   // reset in mid-pixel: outputs drop, the next frame starts clean
   task automatic test_reset;
      frame(`CPFP_FMT_RGB12, 0, 0);
      px(12'h123, 12'h456, 12'h789);
      repeat (3) @(negedge clk);
      srst = 1;
      repeat (2) @(negedge clk);
      chk({7'h00, pix_ready}, 8'h00);
      chk({7'h00, byte_valid}, 8'h00);
      chk(byte_data, 8'h00);
      srst = 0;
      frame(`CPFP_FMT_RGB8, 0, 0);
      px(12'hab0, 12'hcd0, 12'hef0);
      exp_bytes(48'habcdef, 3);
   endtask
   initial begin
      repeat (6) @(negedge clk);
      srst = 0;
      test_yuyv();
      test_mono8();
      test_rgb8();
      test_rgb12();
      test_reset();
      end_of_test();
   end
endmodule
`default_nettype wire

// [cpfp_asserts.sv]
// port checker for the pixel format packer
`timescale 1ns/1ps
`default_nettype none
module cpfp_asserts (
   input wire logic clk,
   input wire logic srst,
   input wire logic frame_start,
   input wire logic [1:0] fmt_sel,
   input wire logic pix_valid,
   input wire logic pix_ready,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_ready
);
   logic [1:0] fmt_q;
   logic odd_q;
   wire acc = byte_valid && byte_ready;
   // byte parity per frame; rgb12 pixels are six bytes so it stays aligned
   always_ff @(posedge clk) begin
      odd_q <= (srst || frame_start) ? 1'b0 : odd_q ^ acc;
      fmt_q <= srst ? 2'h0 : (frame_start ? fmt_sel : fmt_q);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_take;
      pix_valid && pix_ready && !frame_start;
   endsequence
   sequence s_stall;
      byte_valid && !byte_ready;
   endsequence
   AST_ANSWER: assert property (s_take |-> ##2 byte_valid) else $error("late byte");
   AST_HOLD: assert property (s_stall |=> byte_valid && $stable(byte_data))
      else $error("byte dropped");
   AST_BUSY: assert property (byte_valid |-> !pix_ready) else $error("early pixel");
   AST_RST: assert property ($fell(srst) |-> !byte_valid && !pix_ready)
      else $error("reset state");
   AST_CHROMA: assert property (fmt_q == 2'h0 && byte_valid && !odd_q |-> byte_data == 8'h00)
      else $error("chroma set");
   AST_PAD: assert property (fmt_q == 2'h3 && byte_valid && odd_q |-> byte_data[7:4] == 4'h0)
      else $error("pad set");
   AST_ONE: assert property (fmt_q == 2'h1 && acc |=> !byte_valid) else $error("extra");
   AST_PAIR: assert property (fmt_q == 2'h3 && acc && !odd_q |=> byte_valid)
      else $error("no high byte");
endmodule
bind cpfp_packer cpfp_asserts cpfp_asserts_i (.clk(clk), .srst(srst),
   .frame_start(frame_start), .fmt_sel(fmt_sel), .pix_valid(pix_valid), .pix_ready(pix_ready),
   .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready));
`default_nettype wire

// [cpfp_defines.vh]
// constants for the camera pixel format packer
// Function
// - mono yuyv mode sends real 8-bit brightness as Y, U and V always zero
// - yuyv sends Y every pixel, one U and one V per pixel pair
// - colour mono 8 first converts each pixel to luminance-chrominance
// - colour mono 8 outputs one unsigned 8-bit luminance byte per pixel, in order
// - rgb 8 packed outputs red, green, blue bytes per pixel
// - rgb 12 packed gives each component a 16-bit container of 12 bits
// - 12 bits right-aligned, upper four container bits zero
// - each component sent low byte first, then high byte with zero nibble
// - rgb 12 sends six bytes: red lo/hi, green lo/hi, blue lo/hi
// - rgb 12 component values never exceed 0x0fff
// - mono 8 byte maps directly to level 0x00..0xff
// - luminance is 0.30 red plus 0.59 green plus 0.11 blue
`ifndef CPFP_DEFINES_VH
`define CPFP_DEFINES_VH
`define CPFP_FMT_YUYV 2'h0
`define CPFP_FMT_MONO8 2'h1
`define CPFP_FMT_RGB8 2'h2
`define CPFP_FMT_RGB12 2'h3
// luminance weights scaled by 256: 77/256, 151/256, 28/256
`define CPFP_Y_KR 8'h4d
`define CPFP_Y_KG 8'h97
`define CPFP_Y_KB 8'h1c
`define CPFP_HI_PAD 4'h0
`define CPFP_CHROMA_ZERO 8'h00
`endif

// [cpfp_packer.v]
// pixel-to-byte formatter for mono yuyv, y mono 8, rgb 8 and rgb 12 packing
`timescale 1ns/1ps
`default_nettype none
`include "cpfp_defines.vh"
module cpfp_packer (
   // clock and reset
   input wire clk,
   input wire srst,
   // format and frame control
   input wire [1:0] fmt_sel,
   input wire frame_start,
   input wire mono_sensor,
   // pixel input
   input wire pix_valid,
   input wire [11:0] pix_r,
   input wire [11:0] pix_g,
   input wire [11:0] pix_b,
   output reg pix_ready,
   // byte output
   output reg byte_valid,
   output reg [7:0] byte_data,
   input wire byte_ready
);
   // control states
   localparam S_IDLE = 1'b0;
   localparam S_SEND = 1'b1;

   // control registers and their next values
   reg state_q;
   reg state_d;
   reg [1:0] fmt_q;
   reg [1:0] fmt_d;
   reg mono_q;
   reg mono_d;
   reg [2:0] idx_q;
   reg [2:0] idx_d;
   reg [2:0] last_q;
   reg [2:0] last_d;
   // held pixel and its luminance
   reg [11:0] r_q;
   reg [11:0] r_d;
   reg [11:0] g_q;
   reg [11:0] g_d;
   reg [11:0] b_q;
   reg [11:0] b_d;
   reg [7:0] y_q;
   reg [7:0] y_d;
   // next values of the registered outputs
   reg pix_ready_d;
   reg byte_valid_d;
   reg [7:0] byte_data_d;
   // luminance accumulator
   reg [19:0] y_sum;
   // handshakes
   wire take;
   wire emit;

   // top eight bits of a 12-bit component
   function [7:0] top8;
      input [11:0] c;
      begin
         top8 = c[11:4];
      end
   endfunction

   // low byte of a 16-bit little-endian container
   function [7:0] lo8;
      input [11:0] c;
      begin
         lo8 = c[7:0];
      end
   endfunction

   // high byte: zero nibble over bits 11..8, so no value can pass 0x0fff
   function [7:0] hi8;
      input [11:0] c;
      begin
         hi8 = {`CPFP_HI_PAD, c[11:8]};
      end
   endfunction

   // slot index of the last byte of one pixel
   function [2:0] last_slot;
      input [1:0] fmt;
      begin
         case (fmt)
            `CPFP_FMT_YUYV: last_slot = 3'h1;
            `CPFP_FMT_MONO8: last_slot = 3'h0;
            `CPFP_FMT_RGB8: last_slot = 3'h2;
            default: last_slot = 3'h5;
         endcase
      end
   endfunction

   // byte selector for the current slot
   function [7:0] pick;
      input [1:0] fmt;
      input [2:0] idx;
      input [11:0] r;
      input [11:0] g;
      input [11:0] b;
      input [7:0] y;
      begin
         pick = 8'h00;
         case (fmt)
            `CPFP_FMT_YUYV: begin
               // slot 0 is U on even pixels, V on odd ones: one of each per pair
               if (idx == 3'h0) begin
                  pick = `CPFP_CHROMA_ZERO;
               end else begin
                  pick = y;
               end
            end
            `CPFP_FMT_MONO8: begin
               pick = y;
            end
            `CPFP_FMT_RGB8: begin
               case (idx)
                  3'h0: pick = top8(r);
                  3'h1: pick = top8(g);
                  default: pick = top8(b);
               endcase
            end
            default: begin
               case (idx)
                  3'h0: pick = lo8(r);
                  3'h1: pick = hi8(r);
                  3'h2: pick = lo8(g);
                  3'h3: pick = hi8(g);
                  3'h4: pick = lo8(b);
                  default: pick = hi8(b);
               endcase
            end
         endcase
      end
   endfunction

   // luminance from 8-bit components; rounds to nearest instead of truncating
   always @* begin
      y_sum = {12'h000, top8(pix_r)} * {12'h000, `CPFP_Y_KR}
         + {12'h000, top8(pix_g)} * {12'h000, `CPFP_Y_KG}
         + {12'h000, top8(pix_b)} * {12'h000, `CPFP_Y_KB}
         + 20'h00080;
   end

   assign take = pix_valid && pix_ready;
   assign emit = !byte_valid || byte_ready;

   // next-state logic
   always @* begin
      state_d = state_q;
      fmt_d = fmt_q;
      mono_d = mono_q;
      idx_d = idx_q;
      last_d = last_q;
      r_d = r_q;
      g_d = g_q;
      b_d = b_q;
      y_d = y_q;
      pix_ready_d = 1'b0;
      byte_valid_d = byte_valid;
      byte_data_d = byte_data;
      // format latched only at frame start so a frame never mixes packings
      if (frame_start) begin
         fmt_d = fmt_sel;
         mono_d = mono_sensor;
      end
      case (state_q)
         S_IDLE: begin
            if (byte_valid && byte_ready) begin
               byte_valid_d = 1'b0;
            end
            pix_ready_d = !frame_start && emit;
            // limitation: a pixel offered together with frame_start is dropped
            if (take && !frame_start) begin
               r_d = pix_r;
               g_d = pix_g;
               b_d = pix_b;
               // colour sensor converts; mono sensor brightness passes straight
               y_d = mono_q ? top8(pix_g) : y_sum[15:8];
               idx_d = 3'h0;
               last_d = last_slot(fmt_q);
               state_d = S_SEND;
               pix_ready_d = 1'b0;
            end
         end
         S_SEND: begin
            // a byte waits for the sink; the next one replaces it only when taken
            if (emit) begin
               byte_valid_d = 1'b1;
               byte_data_d = pick(fmt_q, idx_q, r_q, g_q, b_q, y_q);
               if (idx_q == last_q) begin
                  state_d = S_IDLE;
               end else begin
                  idx_d = idx_q + 3'h1;
               end
            end
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   // state and output registers
   always @(posedge clk) begin
      if (srst) begin
         state_q <= S_IDLE;
         fmt_q <= `CPFP_FMT_YUYV;
         mono_q <= 1'b1;
         idx_q <= 3'h0;
         last_q <= 3'h0;
         r_q <= 12'h000;
         g_q <= 12'h000;
         b_q <= 12'h000;
         y_q <= 8'h00;
         pix_ready <= 1'b0;
         byte_valid <= 1'b0;
         byte_data <= 8'h00;
      end else begin
         state_q <= state_d;
         fmt_q <= fmt_d;
         mono_q <= mono_d;
         idx_q <= idx_d;
         last_q <= last_d;
         r_q <= r_d;
         g_q <= g_d;
         b_q <= b_d;
         y_q <= y_d;
         pix_ready <= pix_ready_d;
         byte_valid <= byte_valid_d;
         byte_data <= byte_data_d;
      end
   end
endmodule
`default_nettype wire

// [cpfp_sink.sv]
// host buffer model: takes bytes, stalls on request
`timescale 1ns/1ps
`default_nettype none
module cpfp_sink (
   input wire logic clk,
   input wire logic slow,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic byte_ready
);
   logic [7:0] q[$];
   always @(negedge clk) byte_ready <= slow ? ~byte_ready : 1'b1;
   always @(posedge clk) if (byte_valid && byte_ready) q.push_back(byte_data);
endmodule
`default_nettype wire
